/* File: logic/gdcfg_top.sv */
// Purpose: Register file, fault logic and pin routing of the gate driver configuration block.
// Assumes: AHB-Lite slave with zero wait states; comparator pins are asynchronous.
// Notes:   Write lock is sticky until reset; status bits clear by writing one.
//
// The implementer's own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
module gdcfg_top (
    // Clock, reset and enable.
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic        clk_en,
    // AHB-Lite slave port.
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic      [31:0] hrdata,
    output logic             hresp,
    // Asynchronous event pins from the analog comparators.
    input  wire logic        oc0_event_in,
    input  wire logic        oc1_event_in,
    input  wire logic        hv_overvolt_in,
    // Modulator channels.
    input  wire logic [5:0]  pwm_modulator_in,
    // Pre-driver and analog control outputs.
    output logic      [2:0]  highside_gate,
    output logic      [2:0]  lowside_gate,
    output logic             pump_clk_out,
    output logic      [5:0]  oc0_dac_code,
    output logic      [5:0]  oc1_dac_code,
    output logic      [2:0]  lowside_slew_sel,
    // Fault and interrupt outputs.
    output logic      [4:0]  fault_out,
    output logic             irq_out
);

    // State of the block; the pump divider keeps its own.
    typedef struct packed {
        logic [3:0] div_sel;   // Pump divider select code.
        logic       oc0_act;   // Comparator 0 fault action.
        logic       oc0_on;    // Comparator 0 enable.
        logic [3:0] oc0_thr;   // Comparator 0 threshold code.
        logic       oc1_act;   // Comparator 1 fault action.
        logic       oc1_on;    // Comparator 1 enable.
        logic [3:0] oc1_thr;   // Comparator 1 threshold code.
        logic [2:0] slew;      // Low-side slew select.
        logic       pump_en;   // Charge pump enable.
        logic       drv_en;    // Pre-driver enable.
        logic       lock;      // Sticky write lock.
        logic [2:0] stat;      // Sticky event flags.
        logic [2:0] mask;      // Interrupt mask.
        logic [2:0] sync1;     // First synchroniser stage.
        logic [2:0] sync2;     // Second synchroniser stage.
        logic [2:0] hs;        // Registered high-side levels.
        logic [2:0] ls;        // Registered low-side levels.
        logic [5:0] dac0;      // Registered threshold inputs 0.
        logic [5:0] dac1;      // Registered threshold inputs 1.
        logic [4:0] fault;     // Registered fault outputs.
        logic       irq;       // Registered interrupt.
        logic       ap_wr;     // Pending write data phase.
        logic [7:0] ap_addr;   // Address of the pending write.
        logic [31:0] rdata;    // Read data of the current data phase.
        logic       ready;     // Ready output.
        logic       resp;      // Response output.
    } gdcfg_top_s;

    gdcfg_top_s st_reg;
    gdcfg_top_s st_next;

    logic [2:0] route_hs;    // High-side levels from the router.
    logic [2:0] route_ls;    // Low-side levels from the router.
    logic       safe_state;  // Fault response forces the safe pattern.
    logic       addr_phase;  // A transfer is taken this cycle.
    logic       wr_phase;    // A write data phase completes this cycle.
    logic [2:0] set_ev;      // Events raised this cycle.
    logic [2:0] clr_ev;      // Flags cleared by software this cycle.

    // Tests an address against a register offset.
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction

    // Builds the read word for an address from a state image.
    function automatic logic [31:0] read_word(input logic [7:0] addr, input gdcfg_top_s s);
        logic [7:0] v;
        v = 8'h00;
        if (hit(addr, gdcfg_pkg::OFS_CLKDIV))
            v = {4'h0, s.div_sel};
        else if (hit(addr, gdcfg_pkg::OFS_OC0))
            v = {s.oc0_act, s.oc0_on, 2'h0, s.oc0_thr};
        else if (hit(addr, gdcfg_pkg::OFS_OC1))
            v = {s.oc1_act, s.oc1_on, 2'h0, s.oc1_thr};
        else if (hit(addr, gdcfg_pkg::OFS_SLEW))
            v = {5'h00, s.slew};
        else if (hit(addr, gdcfg_pkg::OFS_CTRL))
            v = {5'h00, s.lock, s.drv_en, s.pump_en};
        else if (hit(addr, gdcfg_pkg::OFS_IRQ_STAT))
            v = {5'h00, s.stat};
        else if (hit(addr, gdcfg_pkg::OFS_IRQ_MASK))
            v = {5'h00, s.mask};
        read_word = {24'h000000, v};
    endfunction

    // Bus phase qualifiers.
    assign addr_phase = hsel && htrans[1] && hready;
    assign wr_phase   = st_reg.ap_wr && hready;

    // A raised overcurrent or overvoltage flag with action zero selects the safe pattern.
    assign safe_state = (st_reg.stat[gdcfg_pkg::IRQ_OC0] && !st_reg.oc0_act)
                      || (st_reg.stat[gdcfg_pkg::IRQ_OC1] && !st_reg.oc1_act)
                      || (st_reg.stat[gdcfg_pkg::IRQ_OV] && !st_reg.oc1_act);

    // Channel mapping onto the pre-drivers.
    gdcfg_route gdcfg_route_inst (
        .pwm_modulator (pwm_modulator_in),
        .driver_enable (st_reg.drv_en),
        .safe_state    (safe_state),
        .highside_level(route_hs),
        .lowside_level (route_ls)
    );

    // Charge pump clock generation.
    gdcfg_pump_div gdcfg_pump_div_inst (
        .core_clk              (core_clk),
        .reset_n               (reset_n),
        .clk_en                (clk_en),
        .pump_enable           (st_reg.pump_en),
        .pump_clock_divider_sel(st_reg.div_sel),
        .pump_clk              (pump_clk_out)
    );

    // Next state: register writes, event flags, outputs and bus answer.
    always_comb
    begin
        st_next = st_reg;
        set_ev  = 3'h0;
        clr_ev  = 3'h0;
        // Two-stage synchroniser for the analog event pins.
        st_next.sync1 = {hv_overvolt_in, oc1_event_in, oc0_event_in};
        st_next.sync2 = st_reg.sync1;
        // Overcurrent events count only while their comparator is on.
        set_ev[gdcfg_pkg::IRQ_OC0] = st_reg.sync2[0] && st_reg.oc0_on;
        set_ev[gdcfg_pkg::IRQ_OC1] = st_reg.sync2[1] && st_reg.oc1_on;
        set_ev[gdcfg_pkg::IRQ_OV]  = st_reg.sync2[2];
        if (wr_phase)
        begin
            // Locked configuration fields keep their value.
            if (hit(st_reg.ap_addr, gdcfg_pkg::OFS_CLKDIV) && !st_reg.lock)
            begin
                st_next.div_sel = hwdata[3:0];
            end
            if (hit(st_reg.ap_addr, gdcfg_pkg::OFS_OC0) && !st_reg.lock)
            begin
                st_next.oc0_act = hwdata[gdcfg_pkg::OC_ACTION_BIT];
                st_next.oc0_on  = hwdata[gdcfg_pkg::OC_ON_BIT];
                st_next.oc0_thr = hwdata[3:0];
            end
            if (hit(st_reg.ap_addr, gdcfg_pkg::OFS_OC1) && !st_reg.lock)
            begin
                st_next.oc1_act = hwdata[gdcfg_pkg::OC_ACTION_BIT];
                st_next.oc1_on  = hwdata[gdcfg_pkg::OC_ON_BIT];
                st_next.oc1_thr = hwdata[3:0];
            end
            if (hit(st_reg.ap_addr, gdcfg_pkg::OFS_SLEW))
            begin
                st_next.slew = hwdata[2:0];
            end
            if (hit(st_reg.ap_addr, gdcfg_pkg::OFS_CTRL))
            begin
                // Enables are always writable; the lock can only be set.
                st_next.pump_en = hwdata[gdcfg_pkg::CTRL_PUMP_BIT];
                st_next.drv_en  = hwdata[gdcfg_pkg::CTRL_DRV_BIT];
                st_next.lock    = st_reg.lock || hwdata[gdcfg_pkg::CTRL_LOCK_BIT];
            end
            if (hit(st_reg.ap_addr, gdcfg_pkg::OFS_IRQ_STAT))
            begin
                clr_ev = hwdata[2:0];
            end
            if (hit(st_reg.ap_addr, gdcfg_pkg::OFS_IRQ_MASK))
            begin
                st_next.mask = hwdata[2:0];
            end
        end
        // A new event wins over a clear in the same cycle.
        st_next.stat = (st_reg.stat & ~clr_ev) | set_ev;
        // Registered pin outputs.
        st_next.hs   = route_hs;
        st_next.ls   = route_ls;
        st_next.dac0 = {gdcfg_pkg::DAC_UPPER, st_reg.oc0_thr};
        st_next.dac1 = {gdcfg_pkg::DAC_UPPER, st_reg.oc1_thr};
        // Phase faults for action one, shared fault for action zero or overvoltage.
        for (int f = 0; f < 3; f++)
        begin
            st_next.fault[f] = (st_reg.stat[gdcfg_pkg::IRQ_OC0] && st_reg.oc0_act)
                             || (st_reg.stat[gdcfg_pkg::IRQ_OC1] && st_reg.oc1_act);
        end
        // Low-voltage supervision is outside this block.
        st_next.fault[3] = 1'b0;
        st_next.fault[4] = st_reg.stat[gdcfg_pkg::IRQ_OV]
                         || (st_reg.stat[gdcfg_pkg::IRQ_OC0] && !st_reg.oc0_act)
                         || (st_reg.stat[gdcfg_pkg::IRQ_OC1] && !st_reg.oc1_act);
        st_next.irq = |(st_reg.stat & st_reg.mask);
        // Bus: a write data phase ends, and a new address phase may start.
        if (hready)
        begin
            st_next.ap_wr = addr_phase && hwrite;
            st_next.ap_addr = haddr[7:0];
        end
        if (addr_phase && !hwrite)
        begin
            // Read data reflect any write completing in this very cycle.
            st_next.rdata = read_word(haddr[7:0], st_next);
        end
        st_next.ready = 1'b1;
        st_next.resp  = 1'b0;
    end

    // Registers the block state.
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_reg         <= '0;
            st_reg.div_sel <= gdcfg_pkg::RST_DIV_SEL;
            st_reg.oc0_thr <= gdcfg_pkg::RST_OC_THR;
            st_reg.oc1_thr <= gdcfg_pkg::RST_OC_THR;
            st_reg.slew    <= gdcfg_pkg::RST_SLEW;
            st_reg.stat    <= gdcfg_pkg::RST_IRQ;
            st_reg.mask    <= gdcfg_pkg::RST_IRQ;
            st_reg.dac0    <= {gdcfg_pkg::DAC_UPPER, gdcfg_pkg::RST_OC_THR};
            st_reg.dac1    <= {gdcfg_pkg::DAC_UPPER, gdcfg_pkg::RST_OC_THR};
            st_reg.ready   <= 1'b1;
        end
        else if (clk_en)
        begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state flip-flops.
    assign hreadyout        = st_reg.ready;
    assign hrdata           = st_reg.rdata;
    assign hresp            = st_reg.resp;
    assign highside_gate    = st_reg.hs;
    assign lowside_gate     = st_reg.ls;
    assign oc0_dac_code     = st_reg.dac0;
    assign oc1_dac_code     = st_reg.dac1;
    assign lowside_slew_sel = st_reg.slew;
    assign fault_out        = st_reg.fault;
    assign irq_out          = st_reg.irq;

    // A locked block keeps its overcurrent setup across a write.
    lock_holds_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        clk_en && wr_phase && st_reg.lock && hit(st_reg.ap_addr, gdcfg_pkg::OFS_OC0)
        |=> $stable({st_reg.oc0_act, st_reg.oc0_on, st_reg.oc0_thr}))
        else $error("Locked overcurrent setup changed.");

    // An unlocked divider write lands in the next cycle.
    div_write_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        clk_en && wr_phase && !st_reg.lock && hit(st_reg.ap_addr, gdcfg_pkg::OFS_CLKDIV)
        |=> st_reg.div_sel == $past(hwdata[3:0]))
        else $error("Divider write not taken.");

    // A disabled comparator never raises its flag.
    comp_off_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        !st_reg.oc0_on && !st_reg.stat[gdcfg_pkg::IRQ_OC0] |=> !st_reg.stat[gdcfg_pkg::IRQ_OC0])
        else $error("Flag set by a disabled comparator.");

    // A synchronised event on an enabled comparator sets its flag.
    comp_set_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        clk_en && st_reg.oc1_on && st_reg.sync2[1] |=> st_reg.stat[gdcfg_pkg::IRQ_OC1])
        else $error("Enabled comparator event lost.");

    // Action one on comparator 0 raises the phase faults.
    phase_fault_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        clk_en && st_reg.stat[gdcfg_pkg::IRQ_OC0] && st_reg.oc0_act |=> fault_out[2:0] == 3'h7)
        else $error("Phase faults missing for action one.");

    // Action zero raises the shared fault and forces the safe pattern.
    safe_pattern_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        clk_en && st_reg.drv_en && st_reg.stat[gdcfg_pkg::IRQ_OC0] && !st_reg.oc0_act
        |=> fault_out[4] && highside_gate == 3'h0 && lowside_gate == 3'h7)
        else $error("Safe pattern missing for action zero.");

    // Overvoltage follows the comparator 1 action bit.
    ov_action_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        clk_en && st_reg.drv_en && st_reg.stat[gdcfg_pkg::IRQ_OV] && !st_reg.oc1_act
        |=> highside_gate == 3'h0 && lowside_gate == 3'h7)
        else $error("Overvoltage response ignores action bit.");

    // Threshold converter inputs carry two fixed ones above the code.
    dac_code_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        clk_en |=> oc1_dac_code == {2'h3, $past(st_reg.oc1_thr)})
        else $error("Threshold converter inputs wrong.");

    // Phase 1 follows channels 2 and 3 when running normally.
    route_map_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        clk_en && st_reg.drv_en && !safe_state
        |=> highside_gate[1] == $past(pwm_modulator_in[2]) && lowside_gate[1] == $past(pwm_modulator_in[3]))
        else $error("Channel mapping wrong.");

    // Disabled pre-drivers output nothing.
    drv_off_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        clk_en && !st_reg.drv_en |=> highside_gate == 3'h0 && lowside_gate == 3'h0)
        else $error("Gates driven while pre-drivers disabled.");

    // A slew write reaches the low-side select in the next cycle.
    slew_write_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        clk_en && wr_phase && hit(st_reg.ap_addr, gdcfg_pkg::OFS_SLEW)
        |=> lowside_slew_sel == $past(hwdata[2:0]))
        else $error("Slew write not applied.");

    // An overvoltage flag always raises the shared fault, whatever the action bit.
    ov_fault_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        clk_en && st_reg.stat[gdcfg_pkg::IRQ_OV] |=> fault_out[4])
        else $error("Shared fault missing for overvoltage.");

    // Once set, the write lock stays set until reset.
    lock_sticky_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        st_reg.lock |=> st_reg.lock)
        else $error("Write lock cleared without reset.");

    // An unmasked flag raises the interrupt one cycle later.
    irq_level_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        clk_en && |(st_reg.stat & st_reg.mask) |=> irq_out)
        else $error("Interrupt missing for unmasked flag.");

endmodule

/* File: logic/gdcfg_pkg.sv */
// Purpose: Shared constants for the gate driver pump and overcurrent configuration block.
// Assumes: A 32-bit AHB-Lite register bus; each 8-bit register sits in the low bits of one word.
// Notes:   Offsets are byte addresses; reset values of multi-bit register fields and single-bit field positions live here.
package gdcfg_pkg;

    // Register byte offsets.
    localparam logic [7:0] OFS_CLKDIV   = 8'h00;
    localparam logic [7:0] OFS_OC0      = 8'h04;
    localparam logic [7:0] OFS_OC1      = 8'h08;
    localparam logic [7:0] OFS_SLEW     = 8'h0c;
    localparam logic [7:0] OFS_CTRL     = 8'h10;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

    // Field positions inside the overcurrent registers.
    localparam int OC_ACTION_BIT = 7;
    localparam int OC_ON_BIT     = 6;

    // Field positions inside the control register.
    localparam int CTRL_PUMP_BIT = 0;
    localparam int CTRL_DRV_BIT  = 1;
    localparam int CTRL_LOCK_BIT = 2;

    // Event positions in the status and mask registers.
    localparam int IRQ_OC0 = 0;
    localparam int IRQ_OC1 = 1;
    localparam int IRQ_OV  = 2;

    // Reset values.
    localparam logic [3:0] RST_DIV_SEL = 4'h0;
    localparam logic [3:0] RST_OC_THR  = 4'h0;
    localparam logic [2:0] RST_SLEW    = 3'h0;
    localparam logic [2:0] RST_IRQ     = 3'h0;

    // Fixed upper inputs of the threshold converter.
    localparam logic [1:0] DAC_UPPER = 2'h3;

    // Pump divider factors, indexed by the select code, and counter width.
    localparam int DIV_CNT_W = 10;
    localparam logic [9:0] PUMP_DIV_FACTOR [0:15] = '{
        10'd16, 10'd24, 10'd32, 10'd48, 10'd64, 10'd96, 10'd100, 10'd128,
        10'd192, 10'd200, 10'd256, 10'd384, 10'd400, 10'd512, 10'd768, 10'd800};

    // Last count of one half period for a select code.
    function automatic logic [9:0] div_half_last(input logic [3:0] sel);
        div_half_last = (PUMP_DIV_FACTOR[sel] >> 1) - 10'd1;
    endfunction

endpackage

/* File: logic/gdcfg_pump_div.sv */
// Purpose: Charge pump clock divider with a selectable even factor.
// Assumes: All factors are even, so the output toggles every half factor.
// Notes:   Counter and output are held at zero while the pump is off.
`timescale 1ns/1ps
module gdcfg_pump_div (
    // Clock, reset and enable.
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    input  wire logic       clk_en,
    // Control.
    input  wire logic       pump_enable,
    input  wire logic [3:0] pump_clock_divider_sel,
    // Divided clock.
    output logic            pump_clk
);

    // State of the divider.
    typedef struct packed {
        logic [gdcfg_pkg::DIV_CNT_W-1:0] cnt; // Half period counter.
        logic                            clk; // Divided clock level.
    } gdcfg_div_s;

    gdcfg_div_s st_reg;
    gdcfg_div_s st_next;

    // Counts half periods and toggles the output at the end of each.
    always_comb
    begin
        st_next = st_reg;
        if (!pump_enable)
        begin
            // Idle level and a fresh count while the pump is off.
            st_next.cnt = '0;
            st_next.clk = 1'b0;
        end
        else if (st_reg.cnt >= gdcfg_pkg::div_half_last(pump_clock_divider_sel))
        begin
            // End of a half period of the selected factor.
            st_next.cnt = '0;
            st_next.clk = ~st_reg.clk;
        end
        else
        begin
            st_next.cnt = st_reg.cnt + 10'd1;
        end
    end

    // Registers the divider state.
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            st_reg <= '0;
        else if (clk_en)
            st_reg <= st_next;
    end

    assign pump_clk = st_reg.clk;

    // The output flips exactly when a half period ends.
    half_toggle_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        clk_en && pump_enable && st_reg.cnt == gdcfg_pkg::div_half_last(pump_clock_divider_sel)
        |=> st_reg.clk != $past(st_reg.clk))
        else $error("Pump clock did not toggle at half period end.");

    // A disabled pump leaves the clock low and the count cleared.
    pump_idle_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        clk_en && !pump_enable |=> st_reg.clk == 1'b0 && st_reg.cnt == '0)
        else $error("Pump clock not idle while disabled.");

endmodule

/* File: logic/gdcfg_route.sv */
// Purpose: Maps modulator channels onto high-side and low-side pre-driver levels.
// Assumes: Inputs come from the same clock domain; output is combinational.
// Notes:   With the pre-drivers enabled, the safe state forces high sides off and low sides on.
`timescale 1ns/1ps
module gdcfg_route (
    // Modulator channels.
    input  wire logic [5:0] pwm_modulator,
    // Pre-driver control.
    input  wire logic       driver_enable,
    input  wire logic       safe_state,
    // Pre-driver levels.
    output logic      [2:0] highside_level,
    output logic      [2:0] lowside_level
);

    // Even channels feed high sides, odd channels feed low sides, per phase.
    for (genvar ph = 0; ph < 3; ph++)
    begin : g_phase
        always_comb
        begin
            if (!driver_enable)
            begin
                // Disabled pre-drivers hold both FETs off.
                highside_level[ph] = 1'b0;
                lowside_level[ph]  = 1'b0;
            end
            else if (safe_state)
            begin
                // Fault response overrides the modulator.
                highside_level[ph] = 1'b0;
                lowside_level[ph]  = 1'b1;
            end
            else
            begin
                highside_level[ph] = pwm_modulator[2*ph];
                lowside_level[ph]  = pwm_modulator[2*ph+1];
            end
        end
    end

endmodule

/* File: dv/gdcfg_bridge_model.sv */
// Purpose: Bridge and pump model; drives comparator pins and times the pump clock.
// Assumes: Trip requests come from the bench in the core clock domain.
// Notes:   The period is the cycle count between two rising pump edges.
`timescale 1ns/1ps
module gdcfg_bridge_model (
    // Clock and trip requests.
    input  wire logic        core_clk,
    input  wire logic [2:0]  trip,
    input  wire logic        pump_clk_out,
    // Comparator pins and measured period.
    output logic             oc0_event_in,
    output logic             oc1_event_in,
    output logic             hv_overvolt_in,
    output logic      [15:0] period
);
    logic [15:0] cnt = 16'h0;  // Free-running cycle count.
    logic [15:0] last = 16'h0; // Count at the last rising pump edge.
    logic        prev = 1'b0;  // Pump level one cycle ago.
    // Comparators answer straight away, unsynchronised to the core clock.
    assign {hv_overvolt_in, oc1_event_in, oc0_event_in} = trip;
    // The pump is sampled on the falling edge so that no race with its register arises.
    always @(negedge core_clk)
    begin
        cnt <= cnt + 16'h1;
        prev <= pump_clk_out;
        if (pump_clk_out && !prev)
        begin
            period <= cnt - last;
            last <= cnt;
        end
    end
endmodule

/* File: dv/gate_driver_pump_oc_config_tb.sv */
// Purpose: Self-checking bench for the gate driver configuration block.
// Assumes: Zero-wait AHB-Lite slave; comparator pins come from the bridge model.
// Notes:   All expected values are worked out here.
`timescale 1ns/1ps
module gate_driver_pump_oc_config_tb;
    logic        core_clk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, clk_en = 1'b1;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [5:0]  pwm_modulator_in = 6'h0, oc0_dac_code, oc1_dac_code;
    logic [2:0]  trip = 3'h0, highside_gate, lowside_gate, lowside_slew_sel;
    logic        hreadyout, hresp, oc0_event_in, oc1_event_in, hv_overvolt_in, pump_clk_out, irq_out;
    logic [4:0]  fault_out;
    logic [15:0] period;
    int          err_count = 0, check_count = 0, cyc = 0;
    localparam int FCT [16] = '{16, 24, 32, 48, 64, 96, 100, 128, 192, 200, 256, 384, 400, 512, 768, 800};
    always #2.5 core_clk = ~core_clk;
    gdcfg_top gdcfg_top_inst (
        .core_clk, .reset_n, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .oc0_event_in, .oc1_event_in,
        .hv_overvolt_in, .pwm_modulator_in, .highside_gate, .lowside_gate, .pump_clk_out,
        .oc0_dac_code, .oc1_dac_code, .lowside_slew_sel, .fault_out, .irq_out);
    gdcfg_bridge_model gdcfg_bridge_model_inst (
        .core_clk, .trip, .pump_clk_out, .oc0_event_in, .oc1_event_in, .hv_overvolt_in, .period);
    // Prints the verdict and ends the run.
    task automatic end_sim;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Compares one value and counts the result.
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic nap(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // One AHB-Lite single transfer; waits on hready in both phases.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(n, e, q);
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask
    // Raises comparator pins, judges faults, gates, interrupt and status, then clears.
    task automatic ev(input logic [2:0] t, input logic [31:0] f, g, i, s);
        trip <= t;
        nap(6);
        chk("fault", f, {27'h0, fault_out});
        chk("gates", g, {26'h0, highside_gate, lowside_gate});
        chk("irq", i, {31'h0, irq_out});
        rd(8'h14, s, "status");
        trip <= 3'h0;
        nap(4);
        wr(8'h14, 32'h7);
    endtask
    // Threshold codes, slew select and readback.
    task automatic t_cfg;
        wr(8'h04, 32'hc5);
        wr(8'h08, 32'h4a);
        wr(8'h0c, 32'h5);
        rd(8'h04, 32'hc5, "oc0 reg");
        rd(8'h08, 32'h4a, "oc1 reg");
        rd(8'h24, 32'h0, "unmapped");
        chk("dac0", 32'h35, {26'h0, oc0_dac_code});
        chk("dac1", 32'h3a, {26'h0, oc1_dac_code});
        chk("slew", 32'h5, {29'h0, lowside_slew_sel});
        // A write while the clock enable is low must leave the state frozen.
        clk_en <= 1'b0;
        wr(8'h0c, 32'h2);
        clk_en <= 1'b1;
        chk("slew frozen", 32'h5, {29'h0, lowside_slew_sel});
    endtask
    // Channel routing, comparator enable, fault actions and interrupt masking.
    task automatic t_evt;
        pwm_modulator_in <= 6'h26;
        nap(3);
        chk("gates off", 32'h0, {26'h0, highside_gate, lowside_gate});
        wr(8'h10, 32'h2);
        wr(8'h18, 32'h3);
        wr(8'h04, 32'h80);
        wr(8'h08, 32'h40);
        ev(3'h1, 32'h0, 32'h15, 32'h0, 32'h0);
        wr(8'h04, 32'hc0);
        ev(3'h1, 32'h7, 32'h15, 32'h1, 32'h1);
        ev(3'h2, 32'h10, 32'h7, 32'h1, 32'h2);
        ev(3'h4, 32'h10, 32'h7, 32'h0, 32'h4);
        wr(8'h04, 32'h40);
        ev(3'h1, 32'h10, 32'h7, 32'h1, 32'h1);
    endtask
    // Every divider code: set divider, start pump, time it, stop it.
    task automatic t_pump;
        for (int i = 0; i < 16; i++)
        begin
            wr(8'h00, 32'(i));
            wr(8'h10, 32'h1);
            nap(2 * FCT[i] + 4);
            chk("pump period", 32'(FCT[i]), {16'h0, period});
            wr(8'h10, 32'h0);
            nap(2);
            chk("pump idle", 32'h0, {31'h0, pump_clk_out});
        end
    endtask
    // Lock, then locked writes must be ignored.
    task automatic t_lock;
        wr(8'h10, 32'h4);
        wr(8'h04, 32'h0f);
        wr(8'h00, 32'h7);
        rd(8'h04, 32'h40, "oc0 locked");
        rd(8'h00, 32'hf, "div locked");
    endtask
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            end_sim();
        end
    end
    initial
    begin
        nap(10);
        reset_n <= 1'b1;
        hsel <= 1'b1;
        nap(1);
        t_cfg();
        t_evt();
        t_pump();
        t_lock();
        end_sim();
    end
endmodule
